// ===== include/tcc_consts.vh
// trace capture control: register offsets, field positions, reset values
// assumes a word-indexed register map reached over a 32-bit avalon-mm slave
`ifndef TCC_CONSTS_VH
`define TCC_CONSTS_VH

// ------------------------------------------------------------
// register indices (byte address = index * 4)
// ------------------------------------------------------------
`define TCC_IDX_EXT_INFO     4'hB
`define TCC_IDX_CONTROL      4'hC
`define TCC_IDX_TRIGGER      4'hD
`define TCC_IDX_CAPT_STATUS  4'h9

// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define TCC_CTL_EN           7
`define TCC_CTL_ARM          6
`define TCC_CTL_TAG          5
`define TCC_CTL_BRK          4
`define TCC_CTL_LOOP         0
`define TCC_CTL_IMPL_MASK    8'hF1

// ------------------------------------------------------------
// extended info fields
// ------------------------------------------------------------
`define TCC_FX_PAGED         7
`define TCC_FX_BIT16         0

// ------------------------------------------------------------
// trigger register fields (own map)
// ------------------------------------------------------------
`define TCC_TRG_BEGIN        6
`define TCC_TRG_EVONLY       0

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define TCC_RST_CONTROL      8'h00
`define TCC_RST_EXT_INFO     8'h00
`define TCC_RST_TRIGGER      8'h40

`endif

// ===== hw/tcc_addr_form.v
// trace capture control: builds the 17-bit core address of an access
// assumes page and address inputs are stable in the cycle they are used
`timescale 1ns/1ps

module tcc_addr_form #(
	parameter PAGE_W = 3,
	parameter LOW_W  = 14
) (
	paged,
	page,
	cpu_addr,
	core_addr
);
	input  wire                       paged;
	input  wire [PAGE_W-1:0]          page;
	input  wire [15:0]                cpu_addr;
	output wire [PAGE_W+LOW_W-1:0]    core_addr;

	// paged: page bits above low cpu bits; else leading zero on cpu address
	assign core_addr = paged ? {page, cpu_addr[LOW_W-1:0]} :
		{1'b0, cpu_addr};
endmodule // tcc_addr_form

// ===== hw/tcc_ext_mem.v
// trace capture control: side memory holding paged flag and bit 16
// assumes one write and one read port on the bus clock
`timescale 1ns/1ps

module tcc_ext_mem #(
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	clk,
	wr_en,
	wr_addr,
	wr_data,
	rd_addr,
	rd_data_ff
);
	input  wire          clk;
	input  wire          wr_en;
	input  wire [AW-1:0] wr_addr;
	input  wire [1:0]    wr_data;
	input  wire [AW-1:0] rd_addr;
	output reg  [1:0]    rd_data_ff;

	reg [1:0] mem [0:DEPTH-1];

	always @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data_ff <= mem[rd_addr];
	end
endmodule // tcc_ext_mem

// ===== hw/tcc_trace_ctrl.v
// trace capture control: control, loop suppression and extended info
// assumes cpu bus signals come from logic on clk; secure is a pin input
//
// What this block does
// [R1] extended info bit 7 shows if the presented word was a paged access
// [R2] flag zero: word is event data or unpaged address with bit 16 zero
// [R3] flag one: word is page bits over low fourteen cpu address bits
// [R4] extended info bit 0 shows bit 16 of the presented word's address
// [R5] end-trace reset with enable set and end trigger keeps extended info
// [R6] enable bit 7 is forced low and cannot be set while secure
// [R7] arm bit 6 gates comparing and storing into the trace fifo
// [R8] tag bit 5 picks tag or force breaks; ignored without break enable
// [R9] break enable bit 4 allows trace-end and comparator c break requests
// [R10] loop bit clear: every qualifying change of flow is captured while the trace fifo is not full
// [R11] loop set and address equals comparator c: skip write, keep count
// [R12] loop set and address differs: store word and load comparator c
// [R13] loop setting has no effect in event-only capture modes
// [R14] end-trace reset with enable set and end trigger clears arm and break enable, keeps other control; else all control resets
// [R15] after power-on or other reset extended info reads zero; bits 6-1 zero
// [R16] trigger position bit: zero ends storage, one starts storage
// [R17] software writes to extended info are ignored
`timescale 1ns/1ps
`include "tcc_consts.vh"

module tcc_trace_ctrl #(
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	clk,
	reset_n,
	end_trace_reset,
	secure_pin,
	avs_address,
	avs_read,
	avs_write,
	avs_writedata,
	avs_readdata,
	avs_waitrequest,
	cof_valid,
	cof_paged,
	cof_page,
	cof_addr,
	trigger_hit,
	fifo_pop,
	fifo_wr_ff,
	fifo_word_ff,
	break_tag_ff,
	break_force_ff,
	compc_addr_ff
);
	input  wire        clk;
	input  wire        reset_n;
	input  wire        end_trace_reset;
	input  wire        secure_pin;
	input  wire [3:0]  avs_address;
	input  wire        avs_read;
	input  wire        avs_write;
	input  wire [31:0] avs_writedata;
	output reg  [31:0] avs_readdata;
	output reg         avs_waitrequest;
	input  wire        cof_valid;
	input  wire        cof_paged;
	input  wire [2:0]  cof_page;
	input  wire [15:0] cof_addr;
	input  wire        trigger_hit;
	input  wire        fifo_pop;
	output reg         fifo_wr_ff;
	output reg  [16:0] fifo_word_ff;
	output reg         break_tag_ff;
	output reg         break_force_ff;
	output reg  [16:0] compc_addr_ff;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	reg [7:0]    ctl_ff;
	reg [7:0]    trg_ff;
	reg          paged_ff;
	reg          bit16_ff;
	reg          done_ff;
	reg          started_ff;
	reg          end_rst_ff;
	reg [AW-1:0] wptr_ff;
	reg [AW-1:0] rptr_ff;
	reg [AW:0]   count_ff;
	reg [2:0]    sec_sync_ff;
	reg          secure_ff;
	reg          acc_ff;
	reg          pop_ff;
	reg          trig_pend_ff;

	wire [16:0]  core_addr;
	wire [1:0]   mem_rd;
	wire [AW-1:0] rd_next;
	wire         store;

	localparam [AW:0] DEPTH_C = DEPTH;

	// ------------------------------------------------------------
	// address forming and side memory
	// ------------------------------------------------------------
	tcc_addr_form #(
		.PAGE_W (3),
		.LOW_W  (14)
	) u_form (
		.paged     (cof_paged),
		.page      (cof_page),
		.cpu_addr  (cof_addr),
		.core_addr (core_addr)
	);

	assign rd_next = fifo_pop ? rptr_ff + 1'b1 : rptr_ff;

	tcc_ext_mem #(
		.DEPTH (DEPTH),
		.AW    (AW)
	) u_mem (
		.clk        (clk),
		.wr_en      (store),
		.wr_addr    (wptr_ff),
		.wr_data    ({cof_paged, core_addr[16]}),
		.rd_addr    (rd_next),
		.rd_data_ff (mem_rd)
	);

	// ------------------------------------------------------------
	// secure pin: three flops, change taken when last two agree
	// ------------------------------------------------------------
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sec_sync_ff <= 3'h0;
			secure_ff   <= 1'b1;
		end else begin
			sec_sync_ff <= {sec_sync_ff[1:0], secure_pin};
			if (sec_sync_ff[2] == sec_sync_ff[1]) begin
				secure_ff <= sec_sync_ff[2];
			end
		end
	end

	// ------------------------------------------------------------
	// capture decision
	// ------------------------------------------------------------
	wire en      = ctl_ff[`TCC_CTL_EN];
	wire armed   = en & ctl_ff[`TCC_CTL_ARM];                  // [R7]
	wire begin_m = trg_ff[`TCC_TRG_BEGIN];
	wire evonly  = trg_ff[`TCC_TRG_EVONLY];
	wire window  = begin_m ? started_ff : ~done_ff;            // [R16]
	wire qual    = armed & cof_valid & window;
	wire loop_on = ctl_ff[`TCC_CTL_LOOP] & ~evonly;            // [R13]
	wire loop_eq = loop_on & (core_addr == compc_addr_ff);     // [R11]
	wire full    = (count_ff == DEPTH_C);
	assign store = qual & ~loop_eq & ~full;                    // [R10] [R12]
	wire end_ok  = en & ~begin_m;
	wire brk_on  = ctl_ff[`TCC_CTL_BRK];                       // [R9]
	wire compc_hit = armed & cof_valid & loop_eq;
	wire run_end = armed & (begin_m ? (started_ff & full) :
		trigger_hit);

	// ------------------------------------------------------------
	// trace fifo bookkeeping and capture
	// ------------------------------------------------------------
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wptr_ff      <= {AW{1'b0}};
			rptr_ff      <= {AW{1'b0}};
			count_ff     <= {(AW+1){1'b0}};
			fifo_wr_ff   <= 1'b0;
			fifo_word_ff <= 17'h00000;
			compc_addr_ff <= 17'h00000;
			started_ff   <= 1'b0;
			done_ff      <= 1'b0;
			trig_pend_ff <= 1'b0;
			pop_ff       <= 1'b0;
		end else begin
			fifo_wr_ff   <= store;                             // [R11]
			pop_ff       <= fifo_pop & (count_ff != 0);
			trig_pend_ff <= trigger_hit;
			if (store) begin
				wptr_ff      <= wptr_ff + 1'b1;
				fifo_word_ff <= core_addr;                     // [R2] [R3]
			end
			if (store & loop_on) begin
				compc_addr_ff <= core_addr;                    // [R12]
			end
			if (fifo_pop && count_ff != 0) begin
				rptr_ff <= rptr_ff + 1'b1;
			end
			count_ff <= count_ff + {{AW{1'b0}}, store} -
				{{AW{1'b0}}, fifo_pop && count_ff != 0};
			if (!armed) begin
				started_ff <= 1'b0;
				done_ff    <= 1'b0;
			end else if (trigger_hit) begin
				started_ff <= 1'b1;                            // [R16]
				done_ff    <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// break requests to the cpu
	// ------------------------------------------------------------
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			break_tag_ff   <= 1'b0;
			break_force_ff <= 1'b0;
		end else begin
			break_tag_ff   <= brk_on & ctl_ff[`TCC_CTL_TAG] &
				(run_end | compc_hit);                         // [R8] [R9]
			break_force_ff <= brk_on & ~ctl_ff[`TCC_CTL_TAG] &
				(run_end | compc_hit);                         // [R8] [R9]
		end
	end

	// ------------------------------------------------------------
	// control, trigger and extended info registers
	// ------------------------------------------------------------
	wire wr_ctl = acc_ff & avs_write &
		(avs_address == `TCC_IDX_CONTROL);
	wire wr_trg = acc_ff & avs_write &
		(avs_address == `TCC_IDX_TRIGGER) & ~ctl_ff[`TCC_CTL_ARM];
	wire [7:0] wd = avs_writedata[7:0];

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			end_rst_ff <= 1'b0;
			ctl_ff     <= `TCC_RST_CONTROL;
			trg_ff     <= `TCC_RST_TRIGGER;
			paged_ff   <= 1'b0;
			bit16_ff   <= 1'b0;
		end else begin
			end_rst_ff <= end_trace_reset;
			if (end_trace_reset & ~end_rst_ff) begin
				if (end_ok) begin
					ctl_ff[`TCC_CTL_ARM] <= 1'b0;              // [R14]
					ctl_ff[`TCC_CTL_BRK] <= 1'b0;              // [R14]
					// extended info and trigger held          [R5]
				end else begin
					ctl_ff   <= `TCC_RST_CONTROL;              // [R15]
					trg_ff   <= `TCC_RST_TRIGGER;
					paged_ff <= 1'b0;                          // [R15]
					bit16_ff <= 1'b0;
				end
			end else begin
				if (wr_ctl) begin
					ctl_ff <= wd & `TCC_CTL_IMPL_MASK;
				end else if (run_end & ~begin_m) begin
					ctl_ff[`TCC_CTL_ARM] <= 1'b0;
				end
				if (secure_ff) begin
					ctl_ff[`TCC_CTL_EN] <= 1'b0;               // [R6]
				end
				if (wr_trg) begin
					trg_ff <= wd & 8'hC1;
				end
				// first word into an empty fifo bypasses the side memory,
				// whose registered read would still show the old entry
				if (store && count_ff == 0) begin
					paged_ff <= cof_paged;                     // [R1] [R17]
					bit16_ff <= core_addr[16];                 // [R4]
				end else if (pop_ff) begin
					paged_ff <= mem_rd[1];                     // [R1] [R17]
					bit16_ff <= mem_rd[0];                     // [R4]
				end
			end
		end
	end

	// ------------------------------------------------------------
	// avalon-mm slave: one wait cycle, then answer
	// ------------------------------------------------------------
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			acc_ff          <= 1'b0;
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h00000000;
		end else begin
			acc_ff          <= (avs_read | avs_write) & ~acc_ff;
			avs_waitrequest <= ~((avs_read | avs_write) & ~acc_ff);
			if (avs_read & ~acc_ff) begin
				if (avs_address == `TCC_IDX_EXT_INFO) begin
					avs_readdata <= {24'h000000, paged_ff,
						6'h00, bit16_ff};                      // [R15]
				end else if (avs_address == `TCC_IDX_CONTROL) begin
					avs_readdata <= {24'h000000, ctl_ff};
				end else if (avs_address == `TCC_IDX_TRIGGER) begin
					avs_readdata <= {24'h000000, trg_ff};
				end else if (avs_address == `TCC_IDX_CAPT_STATUS) begin
					avs_readdata <= {27'h0000000, count_ff[3:0],
						armed};
				end else begin
					avs_readdata <= 32'h00000000;
				end
			end
		end
	end
endmodule // tcc_trace_ctrl

// ===== verification/tcc_trace_ctrl_assertions.sv
// checker: port-level relations of the trace capture control top
// assumes bind onto tcc_trace_ctrl; one clock, reset_n active low
`timescale 1ns/1ps

module tcc_trace_ctrl_assertions #(
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic        end_trace_reset,
	input wire logic        secure_pin,
	input wire logic [3:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        cof_valid,
	input wire logic        cof_paged,
	input wire logic [2:0]  cof_page,
	input wire logic [15:0] cof_addr,
	input wire logic        trigger_hit,
	input wire logic        fifo_pop,
	input wire logic        fifo_wr_ff,
	input wire logic [16:0] fifo_word_ff,
	input wire logic        break_tag_ff,
	input wire logic        break_force_ff,
	input wire logic [16:0] compc_addr_ff
);
	logic [16:0] exp_word_ff;
	wire         rd_ack = avs_read && !avs_waitrequest;

	default clocking @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	// word the block should store for the change of flow just seen
	always @(posedge clk)
		exp_word_ff <= cof_paged ? {cof_page, cof_addr[13:0]}
			: {1'h0, cof_addr};

	property p_ack_next;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_ack_next: assert property (p_ack_next)
		else $error("bus answer not one cycle after request");
	property p_ack_one;
		!avs_waitrequest |=> avs_waitrequest;
	endproperty
	a_ack_one: assert property (p_ack_one)
		else $error("waitrequest low for more than one cycle");
	property p_fx_zero;
		rd_ack && avs_address == 4'hB |->
			avs_readdata[6:1] == 6'h00 && avs_readdata[31:8] == 24'h0;
	endproperty
	a_fx_zero: assert property (p_fx_zero)
		else $error("extended info reserved bits not zero");
	property p_secure;
		secure_pin [*8] ##0 (rd_ack && avs_address == 4'hC) |->
			!avs_readdata[7];
	endproperty
	a_secure: assert property (p_secure)
		else $error("enable reads set while secure");
	property p_tf_excl;
		!(break_tag_ff && break_force_ff);
	endproperty
	a_tf_excl: assert property (p_tf_excl)
		else $error("tag and force break together");
	property p_wr_cause;
		fifo_wr_ff |-> $past(cof_valid);
	endproperty
	a_wr_cause: assert property (p_wr_cause)
		else $error("fifo write without change of flow");
	property p_word;
		fifo_wr_ff |-> fifo_word_ff == exp_word_ff;
	endproperty
	a_word: assert property (p_word)
		else $error("stored word has wrong form");
	property p_compc;
		$changed(compc_addr_ff) |->
			fifo_wr_ff && compc_addr_ff == fifo_word_ff;
	endproperty
	a_compc: assert property (p_compc)
		else $error("comparator c loaded without matching store");
endmodule // tcc_trace_ctrl_assertions

bind tcc_trace_ctrl tcc_trace_ctrl_assertions #(.DEPTH(DEPTH), .AW(AW))
	tcc_trace_ctrl_assertions_inst (.*);

// ===== verification/tcc_cpu_model.sv
// partner: cpu core issuing changes of flow and taking break requests
// assumes the bench calls jump from its main process
`timescale 1ns/1ps

module tcc_cpu_model (
	input  wire logic        clk,
	output logic             cof_valid,
	output logic             cof_paged,
	output logic [2:0]       cof_page,
	output logic [15:0]      cof_addr,
	input  wire logic        fifo_wr_ff,
	input  wire logic [16:0] fifo_word_ff,
	input  wire logic        break_tag_ff,
	input  wire logic        break_force_ff
);
	int tag_cnt = 0;
	int force_cnt = 0;

	initial begin
		cof_valid = 1'h0;
		cof_paged = 1'h0;
		cof_page = 3'h0;
		cof_addr = 16'h0;
	end
	always @(posedge clk) begin
		if (break_tag_ff === 1'h1)
			tag_cnt <= tag_cnt + 1;
		if (break_force_ff === 1'h1)
			force_cnt <= force_cnt + 1;
	end
	// one change of flow; returns what the block stored for it
	task jump(input logic p, input logic [2:0] pg, input logic [15:0] a,
		output logic w, output logic [16:0] word);
		@(posedge clk);
		cof_valid <= 1'h1;
		cof_paged <= p;
		cof_page <= pg;
		cof_addr <= a;
		@(posedge clk);
		cof_valid <= 1'h0;
		cof_paged <= ~p;
		cof_addr <= ~a;
		#1;
		w = fifo_wr_ff;
		word = fifo_word_ff;
	endtask
endmodule // tcc_cpu_model

// ===== verification/test_tcc_trace_ctrl.sv
// bench: register, capture, loop, break and end-trace checks
// assumes tcc_trace_ctrl and tcc_cpu_model are compiled before it
`timescale 1ns/1ps

module test_tcc_trace_ctrl;
	logic        clk = 1'h0;
	logic        reset_n = 1'h0;
	logic        end_trace_reset = 1'h0;
	logic        secure_pin = 1'h0;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'h0;
	logic        avs_write = 1'h0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        cof_valid;
	logic        cof_paged;
	logic [2:0]  cof_page;
	logic [15:0] cof_addr;
	logic        trigger_hit = 1'h0;
	logic        fifo_pop = 1'h0;
	logic        fifo_wr_ff;
	logic        break_tag_ff;
	logic        break_force_ff;
	logic [16:0] fifo_word_ff;
	logic [16:0] compc_addr_ff;
	logic        w;
	logic [16:0] word;
	logic [7:0]  q;
	int          err_total = 0;
	int          compares = 0;
	int          cyc = 0;

	tcc_trace_ctrl tcc_trace_ctrl_inst (.clk(clk), .reset_n(reset_n),
		.end_trace_reset(end_trace_reset), .secure_pin(secure_pin),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.cof_valid(cof_valid), .cof_paged(cof_paged), .cof_page(cof_page),
		.cof_addr(cof_addr), .trigger_hit(trigger_hit),
		.fifo_pop(fifo_pop), .fifo_wr_ff(fifo_wr_ff),
		.fifo_word_ff(fifo_word_ff), .break_tag_ff(break_tag_ff),
		.break_force_ff(break_force_ff), .compc_addr_ff(compc_addr_ff));
	tcc_cpu_model tcc_cpu_model_inst (.clk(clk), .cof_valid(cof_valid),
		.cof_paged(cof_paged), .cof_page(cof_page), .cof_addr(cof_addr),
		.fifo_wr_ff(fifo_wr_ff), .fifo_word_ff(fifo_word_ff),
		.break_tag_ff(break_tag_ff), .break_force_ff(break_force_ff));

	initial forever #2.5 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_total++;
			report_and_stop();
		end
	end

	task report_and_stop();
		$display("checks %0d, mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input logic [16:0] got, input logic [16:0] exp);
		compares++;
		if (got !== exp) begin
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
			err_total++;
		end
	endtask
	task bus(input logic wn, input logic [3:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_write <= wn;
		avs_read <= ~wn;
		@(posedge clk);
		while (avs_waitrequest !== 1'h0 && n < 100) begin
			@(posedge clk);
			n++;
		end
		q = avs_readdata[7:0];
		avs_write <= 1'h0;
		avs_read <= 1'h0;
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		bus(1'h1, a, d);
	endtask
	task rd(input logic [3:0] a, input logic [7:0] e);
		bus(1'h0, a, 8'h00);
		chk({9'h0, q}, {9'h0, e});
	endtask
	task jmp(input logic p, input logic [2:0] pg, input logic [15:0] a,
		input logic ew, input logic [16:0] ewd);
		tcc_cpu_model_inst.jump(p, pg, a, w, word);
		chk({16'h0, w}, {16'h0, ew});
		if (ew)
			chk(word, ewd);
	endtask
	task pulse(input logic trg);
		@(posedge clk);
		trigger_hit <= trg;
		end_trace_reset <= ~trg;
		@(posedge clk);
		trigger_hit <= 1'h0;
		end_trace_reset <= 1'h0;
		repeat (4) @(posedge clk);
	endtask
	task brk(input logic [7:0] c, input int et, input int ef);
		int t0;
		int f0;
		t0 = tcc_cpu_model_inst.tag_cnt;
		f0 = tcc_cpu_model_inst.force_cnt;
		wr(4'hC, c);
		pulse(1'h1);
		chk(17'(tcc_cpu_model_inst.tag_cnt - t0), 17'(et));
		chk(17'(tcc_cpu_model_inst.force_cnt - f0), 17'(ef));
		rd(4'hC, c & 8'hBF);
	endtask

	task t_regs();
		rd(4'hC, 8'h00);
		rd(4'hB, 8'h00);
		rd(4'h1, 8'h00);
		wr(4'hB, 8'hFF);
		rd(4'hB, 8'h00);
		secure_pin <= 1'h1;
		repeat (8) @(posedge clk);
		wr(4'hC, 8'h80);
		rd(4'hC, 8'h00);
		secure_pin <= 1'h0;
		repeat (8) @(posedge clk);
	endtask
	task t_capture();
		wr(4'hD, 8'h00);
		wr(4'hC, 8'hC0);
		jmp(1'h1, 3'h5, 16'hFABC, 1'h1, 17'h17ABC);
		rd(4'hB, 8'h81);
		jmp(1'h0, 3'h5, 16'h1234, 1'h1, 17'h01234);
		jmp(1'h0, 3'h5, 16'h1234, 1'h1, 17'h01234);
	endtask
	task t_loop();
		wr(4'hC, 8'hC1);
		jmp(1'h0, 3'h0, 16'h4000, 1'h1, 17'h04000);
		chk(compc_addr_ff, 17'h04000);
		jmp(1'h0, 3'h0, 16'h4000, 1'h0, 17'h0);
		jmp(1'h1, 3'h2, 16'h4000, 1'h1, 17'h08000);
		chk(compc_addr_ff, 17'h08000);
	endtask
	task t_end();
		wr(4'hC, 8'hF1);
		pulse(1'h0);
		rd(4'hC, 8'hA1);
		rd(4'hB, 8'h81);
		wr(4'hD, 8'h40);
		pulse(1'h0);
		rd(4'hC, 8'h00);
		rd(4'hB, 8'h00);
	endtask

	initial begin
		repeat (6) @(posedge clk);
		reset_n <= 1'h1;
		t_regs();
		t_capture();
		t_loop();
		wr(4'hC, 8'h00);
		wr(4'hD, 8'h00);
		brk(8'hF0, 1, 0);
		brk(8'hD0, 0, 1);
		brk(8'hE0, 0, 0);
		t_end();
		report_and_stop();
	end
endmodule // test_tcc_trace_ctrl
